/* File: logic/tdsp_pkg.sv */
package tdsp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_CMP_A = 8'h0c;
    localparam logic [7:0] OFS_CMP_B = 8'h10;
    localparam logic [7:0] OFS_CAP_TOP = 8'h14;
    localparam logic [7:0] OFS_FLAGS = 8'h18;
    localparam logic [7:0] OFS_PIN = 8'h1c;
    // Field positions
    localparam int BIT_OM_A = 7 - 1;
    localparam int BIT_OM_B = 5 - 1;
    localparam int BIT_FRC_A = 3;
    localparam int BIT_FRC_B = 2;
    localparam int BIT_WGM_LO = 0;
    localparam int BIT_WGM_HI = 3;
    localparam int BIT_TSEL = 0;
    localparam int BIT_PIN_DIR = 0;
    localparam int BIT_PIN_DATA = 2;
    localparam int FLG_OVF = 0;
    localparam int FLG_CMP_A = 1;
    localparam int FLG_CMP_B = 2;
    localparam int FLG_CAP = 3;
    // Waveform modes
    localparam logic [3:0] MODE_PC8 = 4'h1;
    localparam logic [3:0] MODE_PC9 = 4'h2;
    localparam logic [3:0] MODE_PC10 = 4'h3;
    localparam logic [3:0] MODE_CTC_CMP = 4'h4;
    localparam logic [3:0] MODE_FAST8 = 4'h5;
    localparam logic [3:0] MODE_FAST9 = 4'h6;
    localparam logic [3:0] MODE_FAST10 = 4'h7;
    localparam logic [3:0] MODE_PFC_CAP = 4'h8;
    localparam logic [3:0] MODE_PFC_CMP = 4'h9;
    localparam logic [3:0] MODE_PC_CAP = 4'ha;
    localparam logic [3:0] MODE_PC_CMP = 4'hb;
    localparam logic [3:0] MODE_CTC_CAP = 4'hc;
    localparam logic [3:0] MODE_FAST_CAP = 4'he;
    localparam logic [3:0] MODE_FAST_CMP = 4'hf;
    // Counter limits
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    // Tick source selection and prescaler masks
    localparam logic [2:0] TSEL_OFF = 3'h0;
    localparam logic [2:0] TSEL_DIV1 = 3'h1;
    localparam logic [2:0] TSEL_DIV8 = 3'h2;
    localparam logic [2:0] TSEL_DIV64 = 3'h3;
    localparam logic [2:0] TSEL_DIV256 = 3'h4;
    localparam logic [2:0] TSEL_DIV1024 = 3'h5;
    localparam logic [2:0] TSEL_EXT_FALL = 3'h6;
    localparam logic [2:0] TSEL_EXT_RISE = 3'h7;
    localparam logic [9:0] PSC_M8 = 10'h007;
    localparam logic [9:0] PSC_M64 = 10'h03f;
    localparam logic [9:0] PSC_M256 = 10'h0ff;
    localparam logic [9:0] PSC_M1024 = 10'h3ff;
    // Output mode codes
    localparam logic [1:0] OM_OFF = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;

    typedef enum logic {TDSP_UP = 1'b0, TDSP_DOWN = 1'b1} tdsp_dir_t;

    typedef struct packed {
        logic [1:0][1:0] om;
        logic [1:0] wgm_lo;
        logic [1:0] wgm_hi;
        logic [2:0] tsel;
        logic [15:0] cnt;
        tdsp_dir_t dir;
        logic block;
        logic [1:0][15:0] cmp_buf;
        logic [1:0][15:0] cmp_act;
        logic [15:0] cap_top;
        logic [3:0] flags;
        logic [1:0] pin_dir;
        logic [1:0] port_data;
        logic [1:0] wave;
        logic [9:0] psc;
        logic [2:0] ext_sync;
        logic [31:0] prdata;
    } tdsp_state_t;
endpackage

/* File: logic/tdsp_pwm_out.sv */
`timescale 1ns/100ps
// What this block does
// - Dual-slope frequency-correct mode counts up to capture or compare A top, then down
// - Counter holds TOP for exactly one tick before it decrements
// - Channel compare flag sets when counter equals active compare value
// - Frequency-correct mode sets overflow flag when buffers load at BOTTOM
// - Compare A or capture flag sets at TOP when that register defines TOP
// - Dual-slope: mode 2 clears on up match, sets on down; 3 inverts
// - Dual-slope compare at BOTTOM gives steady low, at TOP steady high in mode 2; 3 inverts
// - Mode 9 toggle mode toggles output A on match; channel B disconnected
// - Everything runs on the core clock; the tick is only an enable
// - Tick is core clock divided by 1, 8, 64, 256 or 1024, or a falling or rising edge of the external pin
// - Nonzero output mode overrides port data, except 01 in PWM modes where toggle is not allowed; direction bit enables the driver
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// - Fast PWM: 10 clears on match, sets at TOP; 11 reverse; 01 mode 15 only
// - Fast PWM ignores a match at TOP when high mode bit set
// - Force bits act only in non-PWM modes; software writes zero otherwise
// - Force bit write forces a match using the output mode written in the same access
// - Forced match sets no flag and never clears the counter
// - Force bits store nothing and read as zero
// - Control A layout: modes 7:6 and 5:4, force 3 and 2, mode 1:0
// - Dual-slope counts from zero up to TOP and back to zero
// - Four-bit mode is low bits of control A joined with high bits of control B
// - Tick source zero gives no ticks; counter stays stopped
module tdsp_pwm_out
    import tdsp_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_tick_pin,
    output logic pin_out_a,
    output logic pin_oe_a,
    output logic pin_out_b,
    output logic pin_oe_b
);

    tdsp_state_t st_ff;
    tdsp_state_t nxt_st;
    logic [3:0] mode;
    logic pfc, pc, dual, fast, ctc, pwm;
    logic cap_top_mode, cmp_top_mode, tog_ok;
    logic tick, ext_rise, ext_fall;
    logic [15:0] top_val;
    logic at_top, at_bot, upd, ovf_set;
    logic wr_acc, rd_setup, mapped, cnt_wr;
    logic [3:0] flg_set, flg_clr;
    logic [1:0] match, conn, frc, wave_nxt, pin_out, pin_oe;

    // Action of a single match in non-PWM modes
    function automatic logic nonpwm_act(input logic [1:0] om, input logic w);
        logic r;
        r = w;
        unique case (om)
            OM_OFF: r = w;
            OM_TOGGLE: r = ~w;
            OM_CLEAR: r = 1'b0;
            OM_SET: r = 1'b1;
        endcase
        return r;
    endfunction

    // Next output level of one channel under PWM or non-PWM modes
    function automatic logic wave_step(input logic [1:0] om, input logic w,
                                       input logic m, input logic tt,
                                       input logic up, input logic lo,
                                       input logic hi, input logic is_pwm,
                                       input logic is_dual, input logic tog);
        logic r;
        r = w;
        if (!is_pwm) begin
            if (m) begin
                r = nonpwm_act(om, w);
            end
        end else if (om == OM_TOGGLE) begin
            if (tog && m) begin
                r = ~w;
            end
        end else if (om[1]) begin
            if (is_dual) begin
                if (lo) begin
                    r = om[0];
                end else if (hi) begin
                    r = ~om[0];
                end else if (m) begin
                    r = up ? om[0] : ~om[0];
                end
            end else if (tt) begin
                r = ~om[0];
            end else if (m && !hi) begin
                r = om[0];
            end
        end
        return r;
    endfunction

    // TOP for the selected mode
    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ca,
                                           input logic [15:0] ct);
        logic [15:0] t;
        t = CNT_MAX;
        unique case (m)
            MODE_PC8, MODE_FAST8: t = TOP_8BIT;
            MODE_PC9, MODE_FAST9: t = TOP_9BIT;
            MODE_PC10, MODE_FAST10: t = TOP_10BIT;
            MODE_CTC_CMP, MODE_PFC_CMP, MODE_PC_CMP, MODE_FAST_CMP: t = ca;
            MODE_PFC_CAP, MODE_PC_CAP, MODE_CTC_CAP, MODE_FAST_CAP: t = ct;
            default: t = CNT_MAX;
        endcase
        return t;
    endfunction

    // Mode decode
    assign mode = {st_ff.wgm_hi, st_ff.wgm_lo};
    assign pfc = (mode == MODE_PFC_CAP) || (mode == MODE_PFC_CMP);
    assign pc = (mode == MODE_PC8) || (mode == MODE_PC9) || (mode == MODE_PC10)
        || (mode == MODE_PC_CAP) || (mode == MODE_PC_CMP);
    assign fast = (mode == MODE_FAST8) || (mode == MODE_FAST9) || (mode == MODE_FAST10)
        || (mode == MODE_FAST_CAP) || (mode == MODE_FAST_CMP);
    assign ctc = (mode == MODE_CTC_CMP) || (mode == MODE_CTC_CAP);
    assign dual = pfc || pc;
    assign pwm = dual || fast;
    assign cap_top_mode = (mode == MODE_PFC_CAP) || (mode == MODE_PC_CAP)
        || (mode == MODE_CTC_CAP) || (mode == MODE_FAST_CAP);
    assign cmp_top_mode = (mode == MODE_PFC_CMP) || (mode == MODE_PC_CMP)
        || (mode == MODE_CTC_CMP) || (mode == MODE_FAST_CMP);
    assign tog_ok = (mode == MODE_PFC_CMP) || (mode == MODE_PC_CMP) || (mode == MODE_FAST_CMP);
    assign top_val = top_of(mode, st_ff.cmp_act[0], st_ff.cap_top);

    // Tick enable from prescaler or synchronised external pin
    assign ext_rise = st_ff.ext_sync[1] & ~st_ff.ext_sync[2];
    assign ext_fall = ~st_ff.ext_sync[1] & st_ff.ext_sync[2];
    always_comb begin
        unique case (st_ff.tsel)
            TSEL_OFF: tick = 1'b0;
            TSEL_DIV1: tick = 1'b1;
            TSEL_DIV8: tick = (st_ff.psc & PSC_M8) == PSC_M8;
            TSEL_DIV64: tick = (st_ff.psc & PSC_M64) == PSC_M64;
            TSEL_DIV256: tick = (st_ff.psc & PSC_M256) == PSC_M256;
            TSEL_DIV1024: tick = (st_ff.psc & PSC_M1024) == PSC_M1024;
            TSEL_EXT_FALL: tick = ext_fall;
            TSEL_EXT_RISE: tick = ext_rise;
        endcase
    end

    // Counter positions, buffer update point and flag events
    assign at_top = st_ff.cnt == top_val;
    assign at_bot = st_ff.cnt == CNT_BOTTOM;
    assign upd = pwm && tick && (pfc ? at_bot : at_top);
    assign ovf_set = tick && (dual ? at_bot : (fast ? at_top : st_ff.cnt == CNT_MAX));
    assign flg_set[FLG_OVF] = ovf_set;
    assign flg_set[FLG_CMP_A] = match[0] || (cmp_top_mode && tick && at_top);
    assign flg_set[FLG_CMP_B] = match[1];
    assign flg_set[FLG_CAP] = cap_top_mode && tick && at_top;

    // APB decode; zero wait states
    assign mapped = (paddr <= OFS_PIN) && (paddr[1:0] == 2'h0);
    assign wr_acc = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign cnt_wr = wr_acc && (paddr == OFS_COUNT);
    assign flg_clr = (wr_acc && paddr == OFS_FLAGS) ? pwdata[3:0] : 4'h0;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = st_ff.prdata;

    // Per channel match, force, wave and pin override
    for (genvar i = 0; i < 2; i++) begin : g_ch
        assign match[i] = tick && !st_ff.block && (st_ff.cnt == st_ff.cmp_act[i]);
        assign frc[i] = wr_acc && (paddr == OFS_CTRL_A) && pwdata[BIT_FRC_A - i]
            && !pwm;
        assign wave_nxt[i] = frc[i]
            ? nonpwm_act(pwdata[BIT_OM_A - 2 * i +: 2], st_ff.wave[i])
            : wave_step(st_ff.om[i], st_ff.wave[i], match[i], tick && at_top,
                        st_ff.dir == TDSP_UP, st_ff.cmp_act[i] == CNT_BOTTOM,
                        st_ff.cmp_act[i] == top_val, pwm, dual, (i == 0) && tog_ok);
        assign conn[i] = (st_ff.om[i] != OM_OFF)
            && !((st_ff.om[i] == OM_TOGGLE) && pwm && !((i == 0) && tog_ok));
        assign pin_out[i] = conn[i] ? st_ff.wave[i] : st_ff.port_data[i];
        assign pin_oe[i] = st_ff.pin_dir[i];
    end
    assign pin_out_a = pin_out[0];
    assign pin_oe_a = pin_oe[0];
    assign pin_out_b = pin_out[1];
    assign pin_oe_b = pin_oe[1];

    // Next state of the whole block
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ext_sync = {st_ff.ext_sync[1:0], ext_tick_pin};
        nxt_st.psc = st_ff.psc + 10'h001;
        nxt_st.wave = wave_nxt;
        // Counting on the tick enable only
        if (tick) begin
            nxt_st.block = 1'b0;
            if (dual) begin
                if (st_ff.dir == TDSP_UP) begin
                    if (at_top) begin
                        nxt_st.cnt = st_ff.cnt - 16'h0001;
                        nxt_st.dir = TDSP_DOWN;
                    end else begin
                        nxt_st.cnt = st_ff.cnt + 16'h0001;
                    end
                end else if (at_bot) begin
                    nxt_st.cnt = st_ff.cnt + 16'h0001;
                    nxt_st.dir = TDSP_UP;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 16'h0001;
                end
            end else begin
                nxt_st.dir = TDSP_UP;
                if ((fast || ctc) && at_top) begin
                    nxt_st.cnt = CNT_BOTTOM;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 16'h0001;
                end
            end
        end
        // Register writes
        if (wr_acc) begin
            unique case (paddr)
                OFS_CTRL_A: begin
                    nxt_st.om[0] = pwdata[BIT_OM_A +: 2];
                    nxt_st.om[1] = pwdata[BIT_OM_B +: 2];
                    nxt_st.wgm_lo = pwdata[BIT_WGM_LO +: 2];
                end
                OFS_CTRL_B: begin
                    nxt_st.wgm_hi = pwdata[BIT_WGM_HI +: 2];
                    nxt_st.tsel = pwdata[BIT_TSEL +: 3];
                end
                OFS_COUNT: begin
                    nxt_st.cnt = pwdata[15:0];
                    nxt_st.block = 1'b1;
                end
                OFS_CMP_A: nxt_st.cmp_buf[0] = pwdata[15:0];
                OFS_CMP_B: nxt_st.cmp_buf[1] = pwdata[15:0];
                OFS_CAP_TOP: nxt_st.cap_top = pwdata[15:0];
                OFS_PIN: begin
                    nxt_st.pin_dir = pwdata[BIT_PIN_DIR +: 2];
                    nxt_st.port_data = pwdata[BIT_PIN_DATA +: 2];
                end
                default: nxt_st.cnt = nxt_st.cnt;
            endcase
        end
        // Active compare values follow buffers at once in non-PWM modes, else at the update point
        if (!pwm) begin
            nxt_st.cmp_act = nxt_st.cmp_buf;
        end else if (upd) begin
            nxt_st.cmp_act = st_ff.cmp_buf;
        end
        // Sticky flags, set beats clear
        nxt_st.flags = (st_ff.flags & ~flg_clr) | flg_set;
        // Read data captured in the setup phase
        if (rd_setup) begin
            nxt_st.prdata = '0;
            unique case (paddr)
                OFS_CTRL_A: begin
                    nxt_st.prdata[BIT_OM_A +: 2] = st_ff.om[0];
                    nxt_st.prdata[BIT_OM_B +: 2] = st_ff.om[1];
                    nxt_st.prdata[BIT_WGM_LO +: 2] = st_ff.wgm_lo;
                end
                OFS_CTRL_B: begin
                    nxt_st.prdata[BIT_WGM_HI +: 2] = st_ff.wgm_hi;
                    nxt_st.prdata[BIT_TSEL +: 3] = st_ff.tsel;
                end
                OFS_COUNT: nxt_st.prdata[15:0] = st_ff.cnt;
                OFS_CMP_A: nxt_st.prdata[15:0] = st_ff.cmp_buf[0];
                OFS_CMP_B: nxt_st.prdata[15:0] = st_ff.cmp_buf[1];
                OFS_CAP_TOP: nxt_st.prdata[15:0] = st_ff.cap_top;
                OFS_FLAGS: nxt_st.prdata[3:0] = st_ff.flags;
                OFS_PIN: begin
                    nxt_st.prdata[BIT_PIN_DIR +: 2] = st_ff.pin_dir;
                    nxt_st.prdata[BIT_PIN_DATA +: 2] = st_ff.port_data;
                end
                default: nxt_st.prdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_pfc_top;
        tick && pfc && at_top && (st_ff.dir == TDSP_UP) && !cnt_wr;
    endsequence
    sequence s_force_a;
        frc[0] && !match[0] && !st_ff.flags[FLG_CMP_A] && !flg_set[FLG_CMP_A];
    endsequence

    a_top_hold_once: assert property (s_pfc_top
        |=> (st_ff.cnt == $past(top_val) - 16'h0001) && (st_ff.dir == TDSP_DOWN))
        else $error("TOP not held for one tick");
    a_bottom_load: assert property ((tick && pfc && at_bot)
        |=> st_ff.flags[FLG_OVF] && (st_ff.cmp_act[0] == $past(st_ff.cmp_buf[0])))
        else $error("Overflow and buffer load not together");
    a_match_flag_b: assert property (match[1] |=> st_ff.flags[FLG_CMP_B])
        else $error("Compare B flag missed");
    a_cap_top_flag: assert property ((tick && at_top && cap_top_mode)
        |=> st_ff.flags[FLG_CAP]) else $error("Capture flag not set at TOP");
    a_tick_stopped: assert property ((st_ff.tsel == TSEL_OFF) |-> !tick)
        else $error("Tick while stopped");
    a_div_eight: assert property ((tick && st_ff.tsel == TSEL_DIV8)
        |=> (!tick || st_ff.tsel != TSEL_DIV8) [*7]) else $error("Divide by 8 wrong");
    a_ext_pulse: assert property ((tick && st_ff.tsel == TSEL_EXT_RISE)
        |=> (!tick || st_ff.tsel != TSEL_EXT_RISE)) else $error("External tick too long");
    a_pwm_up_clear: assert property ((dual && st_ff.om[1] == OM_CLEAR && match[1]
        && st_ff.dir == TDSP_UP && st_ff.cmp_act[1] != CNT_BOTTOM
        && st_ff.cmp_act[1] != top_val) |=> !st_ff.wave[1])
        else $error("Up match did not clear output");
    a_bottom_low: assert property ((dual && st_ff.om[1] == OM_CLEAR
        && st_ff.cmp_act[1] == CNT_BOTTOM) |=> !st_ff.wave[1])
        else $error("Compare at BOTTOM not low");
    a_fast_top_set: assert property ((fast && tick && at_top
        && st_ff.om[1] == OM_CLEAR) |=> st_ff.wave[1])
        else $error("Fast output not set at TOP");
    a_toggle_half: assert property ((mode == MODE_PFC_CMP && st_ff.om[0] == OM_TOGGLE
        && match[0]) |=> st_ff.wave[0] != $past(st_ff.wave[0]))
        else $error("Toggle missed");
    a_force_set: assert property ((frc[0] && pwdata[BIT_OM_A +: 2] == OM_SET)
        |=> st_ff.wave[0]) else $error("Force did not set output");
    a_force_noflag: assert property (s_force_a |=> !st_ff.flags[FLG_CMP_A])
        else $error("Force set a flag");
    a_force_read: assert property ((rd_setup && paddr == OFS_CTRL_A)
        |=> prdata[BIT_FRC_B +: 2] == 2'h0) else $error("Force bits read nonzero");
endmodule

/* File: verif/tdsp_load.sv */
`timescale 1ns/100ps
// Pin load: a pull-down holds each pad low while its driver is off
module tdsp_load (
    input wire logic out_a,
    input wire logic oe_a,
    input wire logic out_b,
    input wire logic oe_b,
    output logic lvl_a,
    output logic lvl_b
);
    // Pad level seen by the load
    assign lvl_a = oe_a ? out_a : 1'b0;
    assign lvl_b = oe_b ? out_b : 1'b0;
endmodule

/* File: verif/timer16_dual_slope_pwm_out_bench.sv */
`timescale 1ns/100ps
`define CHK(nm, e, s) begin \
    checks_done++; \
    if ((s) !== (e)) begin \
        $display("CHECK FAILED %s expected %h seen %h", nm, e, s); \
        miscompares++; \
    end \
end
module timer16_dual_slope_pwm_out_bench;
    import tdsp_pkg::*;
    logic core_clk, reset_n, psel, penable, pwrite, ext_tick_pin, pready, pslverr;
    logic pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, lvl_a, lvl_b, meas_done;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, meas_val, mon_e, want;
    logic [15:0] top, cv;
    logic [31:0] exp_q[$];
    string name_q[$];
    string mon_n;
    int miscompares, checks_done, cyc, seed, i, n, len;
    int r_md[10] = '{9, 9, 9, 9, 8, 8, 9, 8, 14, 14};
    int r_om[10] = '{2, 3, 2, 3, 2, 3, 2, 2, 2, 3};
    int r_cs[10] = '{0, 0, 1, 2, 2, 1, 0, 0, 2, 0};
    int r_ts[10] = '{1, 1, 1, 1, 1, 2, 2, 7, 1, 2};
    int r_fr[10] = '{0, 0, 1, 0, 0, 0, 0, 0, 0, 0};
    int f_om[4] = '{3, 2, 1, 1};
    int f_ex[4] = '{1, 0, 1, 0};

    tdsp_pwm_out dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_tick_pin(ext_tick_pin), .pin_out_a(pin_out_a),
        .pin_oe_a(pin_oe_a), .pin_out_b(pin_out_b), .pin_oe_b(pin_oe_b));
    tdsp_load load (.out_a(pin_out_a), .oe_a(pin_oe_a), .out_b(pin_out_b), .oe_b(pin_oe_b),
        .lvl_a(lvl_a), .lvl_b(lvl_b));

    // Clock generation
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Verdict and end of run
    task results();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard and square wave on the external tick pin
    always @(posedge core_clk) begin
        cyc++;
        ext_tick_pin <= cyc[2]; // Square wave, one rising edge every 8 cycles
        if (cyc == 20000) begin
            miscompares++;
            results();
        end
    end

    // Result watcher: oldest note against each transfer's slave error, each read's data and each measurement
    always @(posedge core_clk) begin
        if (psel && penable && pready) begin
            if (!pwrite) begin
                mon_n = name_q.pop_front();
                mon_e = exp_q.pop_front();
                `CHK(mon_n, mon_e, prdata)
            end
            mon_n = name_q.pop_front();
            mon_e = exp_q.pop_front();
            `CHK(mon_n, mon_e, {31'h0, pslverr})
        end
        if (meas_done) begin
            mon_n = name_q.pop_front();
            mon_e = exp_q.pop_front();
            `CHK(mon_n, mon_e, meas_val)
        end
    end

    task note(input string nm, input logic [31:0] e);
        name_q.push_back(nm);
        exp_q.push_back(e);
    endtask

    // One APB transfer, held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        note("slave error", 32'(a > OFS_PIN));
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        note(nm, e);
        apb(1'b0, a, $random(seed));
    endtask

    // Pad watch: 0 high time of a, 1 high time of b, 2 edges of a
    task measure(input int sel, input int len, input logic [31:0] e, input string nm);
        int cnt;
        logic prev;
        note(nm, e);
        cnt = 0;
        @(posedge core_clk);
        prev = lvl_a;
        repeat (len) begin
            @(posedge core_clk);
            if (sel == 2) cnt += (lvl_a !== prev);
            else cnt += ((sel == 1 ? lvl_b : lvl_a) === 1'b1);
            prev = lvl_a;
        end
        meas_val <= cnt;
        meas_done <= 1'b1;
        @(posedge core_clk);
        meas_done <= 1'b0;
    endtask

    // Main sequence
    initial begin
        seed = 35;
        {reset_n, psel, penable, pwrite, meas_done} = '0;
        paddr = '0;
        pwdata = '0;
        meas_val = '0;
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(OFS_CTRL_A, 32'h0, "control a reset");
        // Forced matches with the counter stopped
        wr(OFS_PIN, 32'h3);
        for (i = 0; i < 4; i++) begin
            wr(OFS_CTRL_A, 32'(f_om[i] << 6) | 32'h8);
            measure(0, 4, 32'(4 * f_ex[i]), "forced level");
        end
        rd(OFS_CTRL_A, 32'h40, "control a force bits");
        wr(OFS_CTRL_A, 32'h0);
        wr(OFS_PIN, 32'h7);
        measure(0, 4, 32'h4, "port data level");
        wr(OFS_PIN, 32'h6);
        measure(0, 4, 32'h0, "released pad");
        rd(OFS_FLAGS, 32'h0, "flags after force");
        rd(OFS_COUNT, 32'h0, "stopped counter");
        rd(8'h20, 32'h0, "unmapped read");
        // Dual-slope and fast PWM rows
        wr(OFS_PIN, 32'hb);
        top = 16'd4 + 16'($random(seed) & 7);
        wr(OFS_CAP_TOP, {16'h0, top});
        wr(OFS_CMP_A, {16'h0, top});
        for (i = 0; i < 10; i++) begin
            n = (r_ts[i] == 1) ? 1 : 8;
            len = (r_md[i] > 11) ? n * (top + 1) : 2 * n * top;
            cv = (r_cs[i] == 1) ? 16'h0 : top;
            if (r_cs[i] == 0) cv = 16'(1 + ({$random(seed)} % (top - 1)));
            if (r_md[i] > 11) begin
                want = (r_om[i] == 2) ? 32'(n * (cv + 1)) : 32'(n * (top - cv));
            end else begin
                want = (r_om[i] == 2) ? 32'(2 * n * cv) : 32'(2 * n * (top - cv));
            end
            wr(OFS_CMP_B, {16'h0, cv});
            wr(OFS_CTRL_B, 32'(((r_md[i] >> 2) << 3) | r_ts[i]));
            wr(OFS_CTRL_A, 32'((r_om[i] << 4) | (r_fr[i] << 2) | (r_md[i] & 3)));
            repeat (4 * n * top) @(posedge core_clk);
            measure(1, len, want, "pwm high");
            if (i == 0) begin
                rd(OFS_FLAGS, 32'h7, "flags mode 9");
                wr(OFS_FLAGS, 32'hf);
            end
            if (i == 5) rd(OFS_FLAGS, 32'hf, "flags mode 8");
        end
        // Toggle on channel a, channel b falls back to port data
        wr(OFS_CTRL_B, 32'h11);
        wr(OFS_CTRL_A, 32'h51);
        repeat (4 * top) @(posedge core_clk);
        measure(2, 4 * top, 32'h2, "toggle edges");
        measure(1, 2 * top, 32'(2 * top), "channel b port data");
        results();
    end
endmodule
